// ==== design/wiper_ctrl_pkg.sv ====
// Purpose: Shared constants and types for the temperature indexed wiper control block
// Assumes: 125 MHz system clock, byte wide register port
// Notes: Offsets, field positions, reset values and cycle counts live here

package wiper_ctrl_pkg;

  // ****************************************************
  // Register offsets
  // ****************************************************
  localparam logic [7:0] REG_INIT_WIPER = 8'h00;
  localparam logic [7:0] REG_SHADOW_CTRL = 8'h02;
  localparam logic [7:0] REG_MODE_CTRL = 8'h03;
  localparam logic [7:0] REG_TABLE_INDEX = 8'h08;
  localparam logic [7:0] REG_WIPER = 8'h09;
  localparam logic [7:0] REG_TEMP = 8'h0C;
  localparam logic [7:0] REG_VOLT = 8'h0E;
  localparam logic [7:0] REG_TABLE_FIRST = 8'h80;
  localparam logic [7:0] REG_TABLE_LAST = 8'hC7;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int SHADOW_INHIBIT_BIT = 7;
  localparam int UPDATE_MODE_BIT = 0;
  localparam int ADDER_MODE_BIT = 1;

  // ****************************************************
  // Values after reset and fixed encodings
  // ****************************************************
  localparam logic [7:0] INIT_WIPER_RESET = 8'h00;
  localparam logic [7:0] WIPER_RESET = 8'h00;
  localparam logic [7:0] TABLE_INDEX_RESET = 8'h00;
  localparam logic [7:0] TABLE_ENTRY_RESET = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [1:0] MODE_CTRL_FACTORY = 2'h3;
  localparam logic [4:0] SLAVE_ADDR_FIXED = 5'h0A;
  localparam int TABLE_DEPTH = 72;
  localparam logic [6:0] LAST_SLOT = 7'h47;
  localparam logic [7:0] WIPER_MAX = 8'h7F;

  // ****************************************************
  // Temperature to slot arithmetic, 9-bit signed degrees
  // ****************************************************
  localparam logic signed [8:0] TEMP_LOW_LIMIT = 9'sh1D8;
  localparam logic signed [8:0] TEMP_HIGH_LIMIT = 9'sh065;
  localparam logic signed [8:0] TEMP_SLOT_OFFSET = 9'sh029;
  localparam logic signed [8:0] HYST_UP_OFFSET = 9'sh026;
  localparam logic signed [8:0] HYST_DOWN_OFFSET = 9'sh02B;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int CLK_FREQ_MHZ = 125;
  localparam int FRAME_TIME_US = 1000;
  localparam int FRAME_CYCLES_DEFAULT = FRAME_TIME_US * CLK_FREQ_MHZ;

  // Measurement sequencer states
  typedef enum logic [2:0] {
    ST_POWER_UP,
    ST_IDLE,
    ST_INDEX,
    ST_FETCH,
    ST_LOAD
  } seq_state_t;

endpackage : wiper_ctrl_pkg

// ==== design/table_memory.sv ====
// Purpose: Lookup table storage with one write port and one registered read port
// Assumes: Write and read addresses are slot numbers, checked against DEPTH here
// Notes: Contents return to the factory value on reset

`timescale 1ns/1ns

module table_memory #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 72,
  parameter int AW = 7
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic writeEn,
  input wire logic [AW-1:0] writeAddr,
  input wire logic [WIDTH-1:0] writeData,
  input wire logic [AW-1:0] readAddr,
  output logic [WIDTH-1:0] readData
);
  import wiper_ctrl_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] cells;
    logic [WIDTH-1:0] readData;
  } mem_state_t;

  mem_state_t state;
  mem_state_t next_state;

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb begin
    next_state = state;
    if (int'(readAddr) < DEPTH) begin
      next_state.readData = state.cells[readAddr];
    end else begin
      next_state.readData = '0;
    end
    if (writeEn && int'(writeAddr) < DEPTH) begin
      next_state.cells[writeAddr] = writeData;
    end
  end

  // ****************************************************
  // State register
  // ****************************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state.cells <= {DEPTH{TABLE_ENTRY_RESET[WIDTH-1:0]}};
      state.readData <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign readData = state.readData;

endmodule : table_memory

// ==== design/temp_indexed_wiper_control.sv ====
// Purpose: Temperature indexed wiper control with shadowed registers and a byte register port
// Assumes: Serial bit framing happens outside; ADC results arrive on sys_clk
// Notes: Reset stands for power-up; nonvolatile copies start at factory values
//
// Notes on behaviour
// - Temperature result is 8-bit signed two's complement, one degree per count.
// - Temperature result reads at register 0Ch.
// - In update mode 1, every frame period sample temperature and derive the table address.
// - Two-degree windows per slot; at or below D8 gives 80, 65 up gives C7.
// - One degree of hysteresis keeps boundary temperatures from toggling slots.
// - Supply voltage result is 8-bit and reads at register 0Eh.
// - Seven-bit slave address plus direction bit; two select pins give two bits.
// - Slave address is 01010, select high pin, select low pin, direction.
// - Inhibit clear: write to 00h sets wiper and stored initial value.
// - Inhibit set: write to 00h sets wiper only; initial value kept.
// - Read of 00h gives initial value with inhibit clear, wiper with it set.
// - At power-up the wiper loads from the stored initial value.
// - Inhibit bit is bit 7 of 02h, volatile, zero after power-up.
// - Mode writes go to shadow and storage, or shadow only when inhibited.
// - At power-up mode control recalls from its stored copy.
// - Mode bit 1 picks adder mode: table plus initial value, else table direct.
// - Adder mode treats entries as signed; sum clamps to 00h..7Fh.
// - Update mode 0: wiper keeps its last value, results stop refreshing.
// - Update mode 1: temperature picks one of 72 slots which sets the wiper.
// - Update mode 0 disables the converter; result registers are not refreshed.
// - Mode control leaves the factory holding 03h.

`timescale 1ns/1ns

module temp_indexed_wiper_control #(
  parameter int FRAME_CYCLES = wiper_ctrl_pkg::FRAME_CYCLES_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic addressSelectLow,
  input wire logic addressSelectHigh,
  input wire logic addrByteValid,
  input wire logic [7:0] addrByte,
  output logic addrMatch,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  output logic regRvalid,
  input wire logic [7:0] tempSample,
  input wire logic [7:0] voltSample,
  output logic adcEnable,
  output logic [6:0] wiperTap
);
  import wiper_ctrl_pkg::*;

  localparam int CW = $clog2(FRAME_CYCLES + 1);
  localparam logic [CW-1:0] FRAME_LAST = CW'(FRAME_CYCLES - 1);

  typedef struct packed {
    seq_state_t seq;
    logic [CW-1:0] frameCount;
    logic firstFrame;
    logic [7:0] initWiper;
    logic [7:0] wiper;
    logic shadowInhibit;
    logic [1:0] modeShadow;
    logic [1:0] modeStored;
    logic [6:0] slot;
    logic [7:0] tableIndex;
    logic [7:0] tempResult;
    logic [7:0] voltResult;
    logic [1:0] selLowSync;
    logic [1:0] selHighSync;
    logic addrMatch;
    logic readPending;
    logic [7:0] readAddr;
    logic [7:0] regRdata;
    logic regRvalid;
  } ctrl_state_t;

  ctrl_state_t state;
  ctrl_state_t next_state;

  logic tableWrite;
  logic [6:0] tableWriteAddr;
  logic [6:0] tableReadAddr;
  logic [7:0] tableOutputValue;
  logic busTableRead;

  // ****************************************************
  // Lookup table storage
  // ****************************************************
  table_memory #(
    .WIDTH(8),
    .DEPTH(TABLE_DEPTH),
    .AW(7)
  ) u_table (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .writeEn(tableWrite),
    .writeAddr(tableWriteAddr),
    .writeData(regWdata),
    .readAddr(tableReadAddr),
    .readData(tableOutputValue)
  );

  // Bus access into the table window, bus reads take the read port first
  always_comb begin
    tableWriteAddr = 7'(regAddr - REG_TABLE_FIRST);
    tableWrite = regWrite && regAddr >= REG_TABLE_FIRST && regAddr <= REG_TABLE_LAST;
    busTableRead = regRead && regAddr >= REG_TABLE_FIRST && regAddr <= REG_TABLE_LAST;
    tableReadAddr = busTableRead ? tableWriteAddr : state.slot;
  end

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb begin
    logic signed [8:0] temp;
    logic signed [8:0] slotBase;
    logic signed [8:0] sum;
    logic [6:0] nominal;
    logic inhibited;
    temp = 9'sh000;
    slotBase = 9'sh000;
    sum = 9'sh000;
    nominal = 7'h00;
    inhibited = state.shadowInhibit;
    next_state = state;
    next_state.regRvalid = 1'b0;
    next_state.readPending = 1'b0;

    // Address pins are asynchronous straps, two flops before use
    next_state.selLowSync = {state.selLowSync[0], addressSelectLow};
    next_state.selHighSync = {state.selHighSync[0], addressSelectHigh};

    // Slave address compare on the address byte
    next_state.addrMatch = addrByteValid &&
      addrByte[7:1] == {SLAVE_ADDR_FIXED, state.selHighSync[1], state.selLowSync[1]};

    // Frame timer runs freely
    if (state.frameCount == FRAME_LAST) begin
      next_state.frameCount = '0;
    end else begin
      next_state.frameCount = state.frameCount + CW'(1);
    end

    // Slot arithmetic on the sampled result
    temp = {state.tempResult[7], state.tempResult};
    if (temp <= TEMP_LOW_LIMIT) begin
      nominal = 7'h00;
    end else if (temp >= TEMP_HIGH_LIMIT) begin
      nominal = LAST_SLOT;
    end else begin
      nominal = 7'((temp + TEMP_SLOT_OFFSET) >>> 1);
    end
    slotBase = $signed({1'b0, state.slot, 1'b0});
    sum = $signed({2'b00, state.initWiper[6:0]}) + $signed({{2{tableOutputValue[6]}}, tableOutputValue[6:0]});

    // ****************************************************
    // Measurement sequencer
    // ****************************************************
    // One pass per frame in update mode 1: capture, index, fetch, load
    case (state.seq)
      ST_POWER_UP: begin
        next_state.modeShadow = state.modeStored;
        next_state.wiper = state.initWiper;
        next_state.seq = ST_IDLE;
      end
      ST_IDLE: begin
        if (state.frameCount == FRAME_LAST && state.modeShadow[UPDATE_MODE_BIT]) begin
          next_state.tempResult = tempSample;
          next_state.voltResult = voltSample;
          next_state.seq = ST_INDEX;
        end
      end
      ST_INDEX: begin
        if (state.firstFrame) begin
          next_state.slot = nominal;
        end else if (nominal > state.slot && temp >= slotBase - HYST_UP_OFFSET) begin
          next_state.slot = nominal;
        end else if (nominal < state.slot && temp <= slotBase - HYST_DOWN_OFFSET) begin
          next_state.slot = nominal;
        end
        next_state.firstFrame = 1'b0;
        next_state.seq = ST_FETCH;
      end
      ST_FETCH: begin
        next_state.tableIndex = REG_TABLE_FIRST + {1'b0, state.slot};
        // A bus table read owns the read port, so wait a cycle for it
        if (!busTableRead) begin
          next_state.seq = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (!state.modeShadow[UPDATE_MODE_BIT]) begin
          next_state.wiper = state.wiper;
        end else if (state.modeShadow[ADDER_MODE_BIT]) begin
          // Signed entries can push the sum out of the tap range either way
          if (sum < 9'sh000) begin
            next_state.wiper = 8'h00;
          end else if (sum > $signed({1'b0, WIPER_MAX})) begin
            next_state.wiper = WIPER_MAX;
          end else begin
            next_state.wiper = 8'(sum);
          end
        end else begin
          next_state.wiper = {1'b0, tableOutputValue[6:0]};
        end
        next_state.seq = ST_IDLE;
      end
      default: begin
        next_state.seq = ST_IDLE;
      end
    endcase

    // ****************************************************
    // Register port
    // ****************************************************
    // Register writes, a bus write wins over a sequence load
    if (regWrite) begin
      case (regAddr)
        REG_INIT_WIPER: begin
          next_state.wiper = regWdata;
          if (!inhibited) begin
            next_state.initWiper = regWdata;
          end
        end
        REG_SHADOW_CTRL: begin
          next_state.shadowInhibit = regWdata[SHADOW_INHIBIT_BIT];
        end
        REG_MODE_CTRL: begin
          next_state.modeShadow = regWdata[1:0];
          if (!inhibited) begin
            next_state.modeStored = regWdata[1:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Register reads, data two edges after the request
    // The table read port followed the bus address in the request cycle
    if (regRead) begin
      next_state.readPending = 1'b1;
      next_state.readAddr = regAddr;
    end
    if (state.readPending) begin
      next_state.regRvalid = 1'b1;
      if (state.readAddr >= REG_TABLE_FIRST && state.readAddr <= REG_TABLE_LAST) begin
        next_state.regRdata = tableOutputValue;
      end else begin
        case (state.readAddr)
          REG_INIT_WIPER: next_state.regRdata = inhibited ? state.wiper : state.initWiper;
          REG_SHADOW_CTRL: next_state.regRdata = {state.shadowInhibit, 7'h00};
          REG_MODE_CTRL: next_state.regRdata = {6'h00, state.modeShadow};
          REG_TABLE_INDEX: next_state.regRdata = state.tableIndex;
          REG_WIPER: next_state.regRdata = state.wiper;
          REG_TEMP: next_state.regRdata = state.tempResult;
          REG_VOLT: next_state.regRdata = state.voltResult;
          default: next_state.regRdata = 8'h00;
        endcase
      end
    end
  end

  // ****************************************************
  // State register
  // ****************************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state.seq <= ST_POWER_UP;
      state.frameCount <= '0;
      state.firstFrame <= 1'b1;
      state.initWiper <= INIT_WIPER_RESET;
      state.wiper <= WIPER_RESET;
      state.shadowInhibit <= 1'b0;
      state.modeShadow <= MODE_CTRL_FACTORY;
      state.modeStored <= MODE_CTRL_FACTORY;
      state.slot <= 7'h00;
      state.tableIndex <= TABLE_INDEX_RESET;
      state.tempResult <= RESULT_RESET;
      state.voltResult <= RESULT_RESET;
      state.selLowSync <= 2'h0;
      state.selHighSync <= 2'h0;
      state.addrMatch <= 1'b0;
      state.readPending <= 1'b0;
      state.readAddr <= 8'h00;
      state.regRdata <= 8'h00;
      state.regRvalid <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  // Outputs straight from the state register
  assign addrMatch = state.addrMatch;
  assign regRdata = state.regRdata;
  assign regRvalid = state.regRvalid;
  assign adcEnable = state.modeShadow[UPDATE_MODE_BIT];
  assign wiperTap = state.wiper[6:0];

endmodule : temp_indexed_wiper_control

// ==== testbench/wiper_ctrl_assertions.sv ====
// Purpose: Concurrent checks on the wiper control ports
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every instance of the top module
`timescale 1ns/1ns
module wiper_ctrl_assertions #(
  parameter int FRAME_CYCLES = 20
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic addrByteValid,
  input wire logic [7:0] addrByte,
  input wire logic addrMatch,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regRvalid,
  input wire logic adcEnable,
  input wire logic [6:0] wiperTap
);
  import wiper_ctrl_pkg::*;
  // ********
  // Helpers
  // ********
  logic wrWiperQ;
  logic [2:0] offCnt;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Remember a wiper write; count cycles with the converter off
  always_ff @(posedge sys_clk) begin
    wrWiperQ <= regWrite && regAddr == REG_INIT_WIPER;
    if (!rst_n || adcEnable) begin
      offCnt <= 3'h0;
    end else if (offCnt != 3'h7) begin
      offCnt <= offCnt + 3'h1;
    end
  end
  // ********
  // Checks
  // ********
  sequence s_read_req;
    regRead;
  endsequence
  sequence s_wiper_wr;
    regWrite && regAddr == REG_INIT_WIPER;
  endsequence
  property p_wiper_load;
    s_wiper_wr |=> wiperTap == $past(regWdata[6:0]);
  endproperty
  a_read_answer: assert property (s_read_req |-> ##2 regRvalid)
    else $error("Read answer missing");
  a_answer_cause: assert property (regRvalid |-> $past(regRead, 2))
    else $error("Read answer without request");
  a_match_fixed: assert property (addrByteValid && addrByte[7:3] != SLAVE_ADDR_FIXED |=> !addrMatch)
    else $error("Match on foreign address");
  a_match_cause: assert property (addrMatch |-> $past(addrByteValid))
    else $error("Match without address byte");
  a_wiper_write: assert property (p_wiper_load)
    else $error("Wiper write not applied");
  a_mode_off: assert property (regWrite && regAddr == REG_MODE_CTRL && !regWdata[UPDATE_MODE_BIT]
    |-> ##[1:2] !adcEnable)
    else $error("Converter not stopped");
  a_mode_on: assert property (regWrite && regAddr == REG_MODE_CTRL && regWdata[UPDATE_MODE_BIT]
    |-> ##[1:2] adcEnable)
    else $error("Converter not started");
  a_wiper_frozen: assert property (offCnt == 3'h7 && !wrWiperQ |-> $stable(wiperTap))
    else $error("Wiper moved with updates off");
  a_factory_mode: assert property ($rose(rst_n) |-> adcEnable)
    else $error("Update mode not set after reset");
endmodule : wiper_ctrl_assertions

bind temp_indexed_wiper_control wiper_ctrl_assertions #(.FRAME_CYCLES(FRAME_CYCLES)) chk_u (
  .sys_clk, .rst_n, .addrByteValid, .addrByte, .addrMatch, .regWrite, .regRead,
  .regAddr, .regWdata, .regRvalid, .adcEnable, .wiperTap
);

// ==== testbench/adc_model.sv ====
// Purpose: Converter model feeding temperature and supply results
// Assumes: Results are presented on sys_clk
// Notes: When disabled the outputs wander so stale data shows
`timescale 1ns/1ns
module adc_model (
  input wire logic sys_clk,
  input wire logic adcEnable,
  input wire logic [7:0] tempSet,
  input wire logic [7:0] voltSet,
  output logic [7:0] tempSample,
  output logic [7:0] voltSample
);
  // Known values at time zero
  initial begin
    tempSample = 8'h00;
    voltSample = 8'h00;
  end
  // Follow the set values, or toggle while disabled
  always @(posedge sys_clk) begin
    if (adcEnable) begin
      tempSample <= tempSet;
      voltSample <= voltSet;
    end else begin
      tempSample <= ~tempSample;
      voltSample <= ~voltSample;
    end
  end
endmodule : adc_model

// ==== testbench/tb_top.sv ====
// Purpose: Register level test of the wiper control block
// Assumes: Short frame period for simulation
// Notes: Expected values follow the slot and clamp arithmetic
`timescale 1ns/1ns
module tb_top;
  import wiper_ctrl_pkg::*;
  localparam int FRAME = 20;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic addressSelectLow = 1'b0;
  logic addressSelectHigh = 1'b0;
  logic addrByteValid = 1'b0;
  logic [7:0] addrByte = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] tempSet = 8'h00;
  logic [7:0] voltSet = 8'h5A;
  logic addrMatch, regRvalid, adcEnable;
  logic [7:0] regRdata, tempSample, voltSample;
  logic [6:0] wiperTap;
  int numErrors = 0;
  int compares = 0;
  logic [7:0] rTemp [8] = '{8'hD8, 8'h80, 8'hD9, 8'hDB, 8'h64, 8'h65, 8'h7F, 8'hFF};
  logic [7:0] rIdx [8] = '{8'h80, 8'h80, 8'h81, 8'h82, 8'hC6, 8'hC7, 8'hC7, 8'h94};
  logic [7:0] hTemp [7] = '{8'h01, 8'h02, 8'h01, 8'h00, 8'hFF, 8'hFE, 8'hFD};
  logic [7:0] hIdx [7] = '{8'h94, 8'h95, 8'h95, 8'h95, 8'h94, 8'h94, 8'h93};
  logic [7:0] hWip [7] = '{8'h05, 8'h0A, 8'h0A, 8'h0A, 8'h05, 8'h05, 8'h03};
  // Clock and instances
  always #4 sys_clk = ~sys_clk;
  adc_model adc_u (.sys_clk, .adcEnable, .tempSet, .voltSet, .tempSample, .voltSample);
  temp_indexed_wiper_control #(.FRAME_CYCLES(FRAME)) dut_u (
    .sys_clk, .rst_n, .addressSelectLow, .addressSelectHigh, .addrByteValid, .addrByte,
    .addrMatch, .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .regRvalid,
    .tempSample, .voltSample, .adcEnable, .wiperTap
  );
  // ********
  // Tasks
  // ********
  task automatic stopTest();
    if (numErrors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stopTest
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      numErrors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic settle();
    repeat (2 * FRAME + 8) @(posedge sys_clk);
  endtask : settle
  task automatic doReset(input logic [7:0] t);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    tempSet <= t;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask : doReset
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1;
    for (int i = 0; i < 4 && regRvalid !== 1'b1; i++) begin
      tick();
    end
    if (regRvalid !== 1'b1) begin
      numErrors++;
      stopTest();
    end else begin
      chk(regRdata, exp);
    end
  endtask : rd
  task automatic am(input logic [7:0] b, input logic exp);
    @(posedge sys_clk);
    addrByteValid <= 1'b1;
    addrByte <= b;
    @(posedge sys_clk);
    addrByteValid <= 1'b0;
    // Match pulse stands only in the cycle after the byte
    #1;
    chk({7'h00, addrMatch}, {7'h00, exp});
  endtask : am
  // ********
  // Sequence
  // ********
  initial begin
    doReset(8'h00);
    tick();
    chk({1'b0, wiperTap}, WIPER_RESET);
    chk({7'h00, adcEnable}, 8'h01);
    rd(REG_MODE_CTRL, {6'h00, MODE_CTRL_FACTORY});
    rd(REG_SHADOW_CTRL, 8'h00);
    for (int j = 0; j < 4; j++) begin
      @(posedge sys_clk);
      addressSelectLow <= j[0];
      addressSelectHigh <= j[1];
      repeat (3) @(posedge sys_clk);
      am({SLAVE_ADDR_FIXED, j[1:0], 1'b1}, 1'b1);
      am({SLAVE_ADDR_FIXED, ~j[1:0], 1'b0}, 1'b0);
      am({5'h0B, j[1:0], 1'b0}, 1'b0);
    end
    for (int i = 0; i < 8; i++) begin
      doReset(rTemp[i]);
      settle();
      rd(REG_TABLE_INDEX, rIdx[i]);
    end
    rd(REG_TEMP, 8'hFF);
    rd(REG_VOLT, 8'h5A);
    wr(8'h93, 8'h03);
    wr(8'h94, 8'h05);
    wr(8'h95, 8'h0A);
    for (int i = 0; i < 7; i++) begin
      @(posedge sys_clk);
      tempSet <= hTemp[i];
      settle();
      rd(REG_TABLE_INDEX, hIdx[i]);
      chk({1'b0, wiperTap}, hWip[i]);
    end
    rd(8'h95, 8'h0A);
    wr(REG_INIT_WIPER, 8'h7E);
    settle();
    chk({1'b0, wiperTap}, WIPER_MAX);
    rd(REG_INIT_WIPER, 8'h7E);
    wr(8'h93, 8'h70);
    wr(REG_INIT_WIPER, 8'h05);
    settle();
    chk({1'b0, wiperTap}, 8'h00);
    wr(REG_MODE_CTRL, 8'h01);
    settle();
    chk({1'b0, wiperTap}, 8'h70);
    wr(REG_MODE_CTRL, 8'h00);
    settle();
    wr(REG_INIT_WIPER, 8'h25);
    tick();
    chk({1'b0, wiperTap}, 8'h25);
    settle();
    chk({1'b0, wiperTap}, 8'h25);
    rd(REG_WIPER, 8'h25);
    chk({7'h00, adcEnable}, 8'h00);
    rd(REG_TEMP, 8'hFD);
    wr(REG_TEMP, 8'h33);
    rd(REG_TEMP, 8'hFD);
    wr(REG_SHADOW_CTRL, 8'hFF);
    rd(REG_SHADOW_CTRL, 8'h80);
    wr(REG_INIT_WIPER, 8'h11);
    tick();
    chk({1'b0, wiperTap}, 8'h11);
    rd(REG_INIT_WIPER, 8'h11);
    wr(REG_SHADOW_CTRL, 8'h00);
    rd(REG_INIT_WIPER, 8'h25);
    wr(REG_MODE_CTRL, 8'h03);
    rd(REG_MODE_CTRL, 8'h03);
    rd(8'h40, 8'h00);
    stopTest();
  end
  // Cut a hang short
  initial begin
    repeat (100000) @(posedge sys_clk);
    numErrors++;
    stopTest();
  end
endmodule : tb_top
